// ### hdl/sch_consts.svh
// constants for the chip-select hold controller
`ifndef SCH_CONSTS_SVH
`define SCH_CONSTS_SVH

`define SCH_DATA_W     8
`define SCH_SEL_W      2
`define SCH_NUM_CS     4
`define SCH_DLY_W      8
`define SCH_LVL_W      2
`define SCH_BUF_DEPTH  2
`define SCH_BIT_LAST   3'h7
`define SCH_BIT_W      3
`define SCH_CS_IDLE    4'hF
`define SCH_MSB        7

`endif

// ### hdl/sch_pkg.sv
// types for the chip-select hold controller
`include "sch_consts.svh"

package sch_pkg;

  // link-side sequencer states
  typedef enum logic [1:0] {
    LINK_IDLE,
    LINK_SHIFT,
    LINK_DELAY
  } sch_link_state_e;

  // core-side state
  typedef struct packed {
    logic [`SCH_DATA_W-1:0] holdData;
    logic [`SCH_SEL_W-1:0]  holdSel;
    logic                   holdFinal;
    logic                   emptyFlag;
    logic                   reqTog;
    logic                   outstanding;
    logic                   finalPend;
    logic                   ackS1;
    logic                   ackS2;
    logic                   ackSeen;
    logic                   doneS1;
    logic                   doneS2;
    logic                   doneSeen;
    logic                   relS1;
    logic                   relS2;
    logic                   relSeen;
    logic [`SCH_LVL_W-1:0]  inflight;
  } sch_core_s;

  // link-side state
  typedef struct packed {
    logic                                 rstS1;
    logic                                 rstS2;
    sch_link_state_e                      st;
    logic                                 reqS1;
    logic                                 reqS2;
    logic                                 reqSeen;
    logic                                 finS1;
    logic                                 finS2;
    logic [`SCH_NUM_CS-1:0]               keepS1;
    logic [`SCH_NUM_CS-1:0]               keepS2;
    logic [`SCH_NUM_CS*`SCH_DLY_W-1:0]    dlyS1;
    logic [`SCH_NUM_CS*`SCH_DLY_W-1:0]    dlyS2;
    logic                                 misoS1;
    logic                                 misoS2;
    logic [`SCH_DATA_W-1:0]               shift;
    logic [`SCH_DATA_W-1:0]               rx;
    logic [`SCH_DATA_W-1:0]               rxOut;
    logic [`SCH_BIT_W-1:0]                bitCnt;
    logic [`SCH_SEL_W-1:0]                sel;
    logic                                 lastWord;
    logic [`SCH_DLY_W-1:0]                dly;
    logic [`SCH_NUM_CS-1:0]               csN;
    logic                                 sck;
    logic                                 mosi;
    logic                                 ackTog;
    logic                                 doneTog;
    logic                                 relTog;
  } sch_link_s;

endpackage : sch_pkg

// ### hdl/sch_rx_buffer.sv
// two-entry shift buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
`include "sch_consts.svh"

module sch_rx_buffer
  import sch_pkg::*;
#(
  parameter int WIDTH = `SCH_DATA_W,
  parameter int DEPTH = `SCH_BUF_DEPTH
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // fill side
  input  wire logic                  inValid,
  input  wire logic [WIDTH-1:0]      inData,
  output logic                       inReady,
  // drain side
  output logic                       outValid,
  output logic [WIDTH-1:0]           outData,
  input  wire logic                  outReady,
  // occupancy
  output logic [`SCH_LVL_W-1:0]      level
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [DEPTH-1:0]            vld;
  } sch_buf_s;

  sch_buf_s q;
  sch_buf_s n;

  // count of occupied entries
  function automatic logic [`SCH_LVL_W-1:0] sch_count(input logic [DEPTH-1:0] v);
    logic [`SCH_LVL_W-1:0] c;
    c = '0;
    for (int i = 0; i < DEPTH; i++) begin
      c = c + `SCH_LVL_W'(v[i]);
    end
    return c;
  endfunction : sch_count

  // head always sits in entry 0 so the outputs come from flops
  always_comb begin
    logic placed;
    placed = 1'b0;
    n = q;
    if (q.vld[0] && outReady) begin
      for (int i = 0; i < DEPTH-1; i++) begin
        n.mem[i] = q.mem[i+1];
        n.vld[i] = q.vld[i+1];
      end
      n.vld[DEPTH-1] = 1'b0;
    end
    if (inValid && !q.vld[DEPTH-1]) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (!n.vld[i] && !placed) begin
          n.mem[i] = inData;
          n.vld[i] = 1'b1;
          placed   = 1'b1;
        end
      end
    end
    if (rst) begin
      n.vld = '0;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    q <= n;
  end

  // port outputs
  assign inReady  = ~q.vld[DEPTH-1];
  assign outValid = q.vld[0];
  assign outData  = q.mem[0];
  assign level    = sch_count(q.vld);

endmodule : sch_rx_buffer

`default_nettype wire

// ### hdl/sch_chip_select_ctrl.sv
// serial master chip-select hold controller with link-clock shifter
// Behaviour
// - empty flag rises when the holding word moves into the shift register
// - new word for the same select requested before the inter-transfer delay runs out keeps select low
// - select outputs are active low; a held select is driven low
// - per-select programmable delay after each transfer; zero adds none
// - each of four selects has its own keep-select-after-transfer bit
// - keep bit set: select stays low after transfer even without new data
// - held select changes only when a transfer targets another select or a final request releases it
// - final transfer request releases the select when that transfer's inter-transfer delay has run out
// - keep bit clear: no deassertion guaranteed between back-to-back transfers
`timescale 1ns/1ps
`default_nettype none
`include "sch_consts.svh"

module sch_chip_select_ctrl
  import sch_pkg::*;
(
  // core clock and reset
  input  wire logic                              core_clk,
  input  wire logic                              sys_rst,
  // link clock
  input  wire logic                              linkClk,
  // host transmit side
  input  wire logic                              txWrite,
  input  wire logic [`SCH_DATA_W-1:0]            txData,
  input  wire logic [`SCH_SEL_W-1:0]             txSelect,
  input  wire logic                              finalTransferRequest,
  output logic                                   txHoldingEmptyFlag,
  // per-select configuration
  input  wire logic [`SCH_NUM_CS-1:0]            keepSelectAfterTransfer,
  input  wire logic [`SCH_NUM_CS*`SCH_DLY_W-1:0] interTransferDelay,
  // host receive side
  output logic                                   rxValid,
  output logic [`SCH_DATA_W-1:0]                 rxData,
  input  wire logic                              rxReady,
  // serial pins
  output logic                                   spiSck,
  output logic                                   spiMosi,
  input  wire logic                              spiMiso,
  output logic [`SCH_NUM_CS-1:0]                 periphSelectN
);

  sch_core_s cq;
  sch_core_s cn;
  sch_link_s lq;
  sch_link_s ln;

  logic                    bufInReady;
  logic [`SCH_LVL_W-1:0]   bufLevel;
  logic                    ackEdge;
  logic                    doneEdge;
  logic                    relEdge;
  logic                    launch;
  logic                    reqNew;
  logic                    delayDone;
  logic                    releaseNow;

  // active-low one-hot select pattern
  function automatic logic [`SCH_NUM_CS-1:0] sel_mask_n(input logic [`SCH_SEL_W-1:0] s);
    return ~(`SCH_NUM_CS'(1) << s);
  endfunction : sel_mask_n

  // delay field of one select
  function automatic logic [`SCH_DLY_W-1:0] sel_delay(
    input logic [`SCH_NUM_CS*`SCH_DLY_W-1:0] v,
    input logic [`SCH_SEL_W-1:0]             s
  );
    return v[s*`SCH_DLY_W +: `SCH_DLY_W];
  endfunction : sel_delay

  // core-domain events from the link toggles
  assign ackEdge  = cq.ackS2 != cq.ackSeen;
  assign doneEdge = cq.doneS2 != cq.doneSeen;
  assign relEdge  = cq.relS2 != cq.relSeen;
  // launch only with room reserved for every received word in flight
  assign launch   = !cq.emptyFlag && !cq.outstanding
                    && (cq.inflight + bufLevel) < `SCH_BUF_DEPTH;

  // core-domain next state
  always_comb begin
    cn = cq;
    cn.ackS1  = lq.ackTog;
    cn.ackS2  = cq.ackS1;
    cn.doneS1 = lq.doneTog;
    cn.doneS2 = cq.doneS1;
    cn.relS1  = lq.relTog;
    cn.relS2  = cq.relS1;
    cn.inflight = `SCH_LVL_W'(cq.inflight + `SCH_LVL_W'(ackEdge) - `SCH_LVL_W'(doneEdge));
    if (doneEdge) begin
      cn.doneSeen = cq.doneS2;
    end
    if (ackEdge) begin
      cn.ackSeen     = cq.ackS2;
      cn.outstanding = 1'b0;
      cn.emptyFlag   = 1'b1;
    end
    if (launch) begin
      cn.reqTog      = ~cq.reqTog;
      cn.outstanding = 1'b1;
      cn.holdFinal   = cq.holdFinal | cq.finalPend;
      cn.finalPend   = 1'b0;
    end
    if (relEdge) begin
      cn.relSeen   = cq.relS2;
      cn.finalPend = 1'b0;
    end
    // a final request for a word not yet launched travels with that word
    if (finalTransferRequest) begin
      if (!cq.emptyFlag && !cq.outstanding) begin
        cn.holdFinal = 1'b1;
      end else begin
        cn.finalPend = 1'b1;                       // set wins over clear
      end
    end
    if (txWrite && cq.emptyFlag) begin
      cn.holdData  = txData;
      cn.holdSel   = txSelect;
      cn.holdFinal = 1'b0;
      cn.emptyFlag = 1'b0;
    end
    if (sys_rst) begin
      cn = '0;
      cn.emptyFlag = 1'b1;
    end
  end

  // core-domain register
  always_ff @(posedge core_clk) begin
    cq <= cn;
  end

  // link-domain decode
  assign reqNew     = lq.reqS2 != lq.reqSeen;
  assign delayDone  = lq.st == LINK_DELAY && lq.dly == '0;
  // a crossed final level belongs to a word that is already waiting
  assign releaseNow = lq.lastWord || (lq.finS2 && !reqNew);

  // link-domain next state
  always_comb begin
    ln = lq;
    ln.rstS1  = sys_rst;
    ln.rstS2  = lq.rstS1;
    ln.reqS1  = cq.reqTog;
    ln.reqS2  = lq.reqS1;
    ln.finS1  = cq.finalPend;
    ln.finS2  = lq.finS1;
    ln.keepS1 = keepSelectAfterTransfer;
    ln.keepS2 = lq.keepS1;
    ln.dlyS1  = interTransferDelay;
    ln.dlyS2  = lq.dlyS1;
    ln.misoS1 = spiMiso;
    ln.misoS2 = lq.misoS1;
    unique case (lq.st)
      LINK_IDLE: begin
        if (reqNew) begin
          ln.shift   = cq.holdData;               // holding word stable while requested
          ln.sel     = cq.holdSel;
          ln.lastWord = cq.holdFinal;
          ln.reqSeen = lq.reqS2;
          ln.ackTog  = ~lq.ackTog;
          ln.csN     = sel_mask_n(cq.holdSel);
          ln.bitCnt  = '0;
          ln.mosi    = cq.holdData[`SCH_MSB];
          ln.st      = LINK_SHIFT;
        end else if (lq.finS2 && lq.csN != `SCH_CS_IDLE) begin
          ln.csN    = `SCH_CS_IDLE;
          ln.relTog = ~lq.relTog;
        end
      end
      LINK_SHIFT: begin
        if (!lq.sck) begin
          ln.sck = 1'b1;
          // synchroniser lag: each reply bit shows one rise late, so skip the first
          if (lq.bitCnt != '0) begin
            ln.rx = {lq.rx[`SCH_DATA_W-2:0], lq.misoS2};
          end
        end else begin
          ln.sck = 1'b0;
          if (lq.bitCnt == `SCH_BIT_LAST) begin
            ln.dly     = sel_delay(lq.dlyS2, lq.sel);
            ln.st      = LINK_DELAY;
          end else begin
            ln.bitCnt = `SCH_BIT_W'(lq.bitCnt + 1'b1);
            ln.shift  = {lq.shift[`SCH_DATA_W-2:0], 1'b0};
            ln.mosi   = lq.shift[`SCH_MSB-1];
          end
        end
      end
      LINK_DELAY: begin
        // last reply bit arrives through the synchroniser one cycle after the frame
        if (lq.bitCnt == `SCH_BIT_LAST) begin
          ln.rxOut   = {lq.rx[`SCH_DATA_W-2:0], lq.misoS2};
          ln.doneTog = ~lq.doneTog;
          ln.bitCnt  = '0;
        end
        if (lq.dly != '0) begin
          ln.dly = `SCH_DLY_W'(lq.dly - 1'b1);
        end else begin
          ln.st = LINK_IDLE;
          if (releaseNow) begin
            ln.csN    = `SCH_CS_IDLE;
            ln.relTog = ~lq.relTog;
          end else if (!lq.keepS2[lq.sel]
                       && !(reqNew && cq.holdSel == lq.sel)) begin
            ln.csN = `SCH_CS_IDLE;
          end
        end
      end
    endcase
    if (lq.rstS2) begin
      ln       = '0;
      ln.rstS1 = sys_rst;
      ln.rstS2 = lq.rstS1;
      ln.st    = LINK_IDLE;
      ln.csN   = `SCH_CS_IDLE;
    end
  end

  // link-domain register
  always_ff @(posedge linkClk) begin
    lq <= ln;
  end

  // received words wait here for the host
  sch_rx_buffer #(
    .WIDTH (`SCH_DATA_W),
    .DEPTH (`SCH_BUF_DEPTH)
  ) sch_rx_buffer_inst (
    .clk      (core_clk),
    .rst      (sys_rst),
    .inValid  (doneEdge),
    .inData   (lq.rxOut),
    .inReady  (bufInReady),
    .outValid (rxValid),
    .outData  (rxData),
    .outReady (rxReady),
    .level    (bufLevel)
  );

  // pin and flag outputs
  assign txHoldingEmptyFlag = cq.emptyFlag;
  assign spiSck             = lq.sck;
  assign spiMosi            = lq.mosi;
  assign periphSelectN      = lq.csN;

  // core-domain checks
  a_flag_on_move: assert property (@(posedge core_clk) disable iff (sys_rst)
    ackEdge |=> cq.emptyFlag) else $error("empty flag not raised on shift load");
  a_write_takes_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    (txWrite && cq.emptyFlag) |=> !cq.emptyFlag ##1 !cq.emptyFlag)
    else $error("holding write did not clear empty flag");
  a_rx_room_kept: assert property (@(posedge core_clk) disable iff (sys_rst)
    doneEdge |-> bufInReady) else $error("received word arrived with buffer full");

  // link-domain checks
  a_select_low_one: assert property (@(posedge linkClk) disable iff (lq.rstS2)
    lq.st == LINK_SHIFT |-> lq.csN == sel_mask_n(lq.sel))
    else $error("wrong select pattern during shift");
  a_shift_length: assert property (@(posedge linkClk) disable iff (lq.rstS2)
    (lq.st == LINK_IDLE && reqNew) |=> (lq.st == LINK_SHIFT)[*8] ##1
      (lq.st == LINK_SHIFT)[*8] ##1 lq.st == LINK_DELAY)
    else $error("transfer not sixteen link cycles");
  a_delay_counts: assert property (@(posedge linkClk) disable iff (lq.rstS2)
    (lq.st == LINK_DELAY && lq.dly != '0) |=>
      (lq.st == LINK_DELAY && lq.dly == $past(lq.dly) - 1'b1))
    else $error("inter-transfer delay miscounted");
  a_keep_holds: assert property (@(posedge linkClk) disable iff (lq.rstS2)
    (delayDone && !releaseNow && lq.keepS2[lq.sel]) |=> $stable(lq.csN))
    else $error("kept select changed after transfer");
  a_same_sel_kept: assert property (@(posedge linkClk) disable iff (lq.rstS2)
    (delayDone && !releaseNow && reqNew && cq.holdSel == lq.sel) |=> $stable(lq.csN) ##1
      lq.csN == sel_mask_n(lq.sel)) else $error("select dropped between same-select words");
  a_idle_stable: assert property (@(posedge linkClk) disable iff (lq.rstS2)
    (lq.st == LINK_IDLE && !reqNew && !lq.finS2) |=> $stable(lq.csN))
    else $error("idle select changed without request");
  a_final_release: assert property (@(posedge linkClk) disable iff (lq.rstS2)
    (delayDone && releaseNow) |=> lq.csN == `SCH_CS_IDLE)
    else $error("final transfer did not release select");
  a_nokeep_release: assert property (@(posedge linkClk) disable iff (lq.rstS2)
    (delayDone && !releaseNow && !lq.keepS2[lq.sel] && !reqNew) |=>
      lq.csN == `SCH_CS_IDLE) else $error("unkept select not released");

endmodule : sch_chip_select_ctrl

`default_nettype wire

// ### tb/sch_slave_model.sv
// behavioural serial slave that answers with part of the last word it received
`timescale 1ns/1ps
`default_nettype none
`include "sch_consts.svh"

module sch_slave_model
  import sch_pkg::*;
(
  // serial pins
  input  wire logic                   spiSck,
  input  wire logic                   spiMosi,
  output var logic                    spiMiso,
  input  wire logic [`SCH_NUM_CS-1:0] periphSelectN,
  // last word seen on the wire
  output var logic [`SCH_DATA_W-1:0]  gotWord,
  output var int                      gotCount
);
  logic [`SCH_DATA_W-1:0] inShift;
  logic [`SCH_DATA_W-1:0] outShift;
  int                     nBits;

  // power-up state of the slave
  initial begin
    spiMiso  = 1'b0;
    gotWord  = '0;
    gotCount = 0;
    inShift  = '0;
    outShift = 8'h81;
    nBits    = 0;
  end

  // a released line shows the inverse of its last level, a new frame its first bit
  always @(periphSelectN) begin
    if (periphSelectN == `SCH_CS_IDLE) begin
      spiMiso = ~spiMiso;
      nBits   = 0;
    end else begin
      spiMiso = outShift[`SCH_MSB];
    end
  end

  // sample mosi as the clock rises, most significant bit first
  always @(posedge spiSck) begin
    inShift = {inShift[`SCH_MSB-1:0], spiMosi};
    nBits   = nBits + 1;
  end

  // shift the reply as the clock falls; bit 0 equals the next reply's top bit
  always @(negedge spiSck) begin
    if (nBits == `SCH_DATA_W) begin
      gotWord  = inShift;
      gotCount = gotCount + 1;
      outShift = {1'b1, inShift[5:0], 1'b1};
      nBits    = 0;
    end else if (nBits != 0) begin
      outShift = {outShift[`SCH_MSB-1:0], 1'b1};
      spiMiso  = outShift[`SCH_MSB];
    end
  end
endmodule : sch_slave_model
`default_nettype wire

// ### tb/spi_chip_select_hold_control_bench.sv
// self-checking bench for the chip-select hold controller
`timescale 1ns/1ps
`default_nettype none
`include "sch_consts.svh"

module spi_chip_select_hold_control_bench
  import sch_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        linkClk = 1'b0;
  logic        txWrite, finalTransferRequest, txHoldingEmptyFlag, rxValid, rxReady;
  logic [7:0]  txData, rxData, gotWord, lastSent;
  logic [1:0]  txSelect, lastSel;
  logic [3:0]  keepSelectAfterTransfer, periphSelectN, prevSel;
  logic [31:0] interTransferDelay;
  logic        spiSck, spiMosi, spiMiso, prevFlag;
  logic [31:0] rxQ[$];
  logic [31:0] mosiQ[$];
  int          gotCount, nFail, compares, nRise, gap, lastGap, rdyMode, nSent;

  // clocks of the two domains
  always #10 core_clk = ~core_clk;
  always #7.5 linkClk = ~linkClk;

  sch_chip_select_ctrl sch_chip_select_ctrl_inst (.core_clk(core_clk), .sys_rst(sys_rst),
    .linkClk(linkClk), .txWrite(txWrite), .txData(txData), .txSelect(txSelect),
    .finalTransferRequest(finalTransferRequest), .txHoldingEmptyFlag(txHoldingEmptyFlag),
    .keepSelectAfterTransfer(keepSelectAfterTransfer), .interTransferDelay(interTransferDelay),
    .rxValid(rxValid), .rxData(rxData), .rxReady(rxReady), .spiSck(spiSck),
    .spiMosi(spiMosi), .spiMiso(spiMiso), .periphSelectN(periphSelectN));

  sch_slave_model sch_slave_model_inst (.spiSck(spiSck), .spiMosi(spiMosi), .spiMiso(spiMiso),
    .periphSelectN(periphSelectN), .gotWord(gotWord), .gotCount(gotCount));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      nFail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finishTest;
    $display("compares %0d mismatches %0d", compares, nFail);
    if (nFail == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finishTest

  // one host write once the holding register is free, then an optional final request
  task automatic send(input logic [1:0] sel, input logic fin);
    int n;
    n = 0;
    while (txHoldingEmptyFlag !== 1'b1 && n < 2000) begin
      @(negedge core_clk);
      n++;
    end
    check(n < 2000, 1'b1);
    if (n > 0) @(negedge core_clk);
    txWrite = 1'b1;
    txData = 8'($urandom);
    txSelect = sel;
    rxQ.push_back({24'h0, 1'b1, lastSent[5:0], 1'b1});
    mosiQ.push_back({24'h0, txData});
    lastSent = txData;
    lastSel = sel;
    nSent++;
    @(negedge core_clk);
    txWrite = 1'b0;
    finalTransferRequest = fin;
    @(negedge core_clk);
    finalTransferRequest = 1'b0;
  endtask : send

  // wait until every word has been seen on both sides and the delays have run out
  task automatic drain;
    int n;
    n = 0;
    while ((rxQ.size() != 0 || mosiQ.size() != 0) && n < 3000) begin
      @(negedge core_clk);
      n++;
    end
    check(n < 3000, 1'b1);
    repeat (60) @(negedge core_clk);
  endtask : drain

  // receive handshake: ready always, random, or stalled
  always @(negedge core_clk) begin
    rxReady <= (rdyMode == 0) ? 1'b1 : (rdyMode == 1) ? 1'($urandom % 2) : 1'b0;
  end

  // each delivered word is compared with the oldest note
  always @(posedge core_clk) begin
    if (!sys_rst && rxValid === 1'b1 && rxReady === 1'b1) begin
      check({24'h0, rxData}, rxQ.size() != 0 ? rxQ.pop_front() : 32'hX);
    end
  end

  // each word seen by the slave is compared with what was written
  always @(gotCount) begin
    check({24'h0, gotWord}, mosiQ.size() != 0 ? mosiQ.pop_front() : 32'hX);
  end

  // flag rise: the newest word is on the wire and the previous ones are done
  always @(negedge core_clk) begin
    if (!sys_rst && txHoldingEmptyFlag === 1'b1 && !prevFlag) begin
      check(gotCount, nSent - 1);
      check(periphSelectN[lastSel], 1'b0);
    end
    prevFlag = (txHoldingEmptyFlag !== 1'b0);
  end

  // select watch: rising lines, clock gap before release, one select at a time
  always @(negedge linkClk) begin
    gap = (spiSck === 1'b1) ? 0 : gap + 1;
    if (prevSel != 4'hF && periphSelectN == 4'hF) lastGap = gap;
    nRise += $countones(~prevSel & periphSelectN);
    if (!sys_rst && $countones(~periphSelectN) > 1) check(periphSelectN, 4'hF);
    prevSel = periphSelectN;
  end

  // watchdog: the tests need a few thousand core cycles
  initial begin
    #1000000;
    nFail++;
    finishTest;
  end

  initial begin
    int d;
    int g0;
    int r;
    logic [1:0] s;
    void'($urandom(32'h41F293F2));
    {txWrite, finalTransferRequest, txData, txSelect} = '0;
    {rdyMode, nSent, nRise, gap, lastGap, nFail, compares} = '0;
    {keepSelectAfterTransfer, interTransferDelay, lastSent, lastSel} = '0;
    prevSel = 4'hF;
    prevFlag = 1'b1;
    rxReady = 1'b1;
    repeat (8) @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (6) @(negedge core_clk);
    check(periphSelectN, 4'hF);
    check({txHoldingEmptyFlag, rxValid}, 2'h2);
    $display("test reset done");
    // delay zero, then a random delay, on one select
    rdyMode = 1;
    s = 2'($urandom);
    for (int i = 0; i < 2; i++) begin
      d = (i == 0) ? 0 : 1 + $urandom % 30;
      interTransferDelay = $urandom;
      interTransferDelay[s*8 +: 8] = 8'(d);
      send(s, 1'b0);
      drain;
      check(periphSelectN, 4'hF);
      if (i == 0) g0 = lastGap;
    end
    check(lastGap - g0, d);
    $display("test delay done");
    // back-to-back words on each select keep it low, then it is released
    rdyMode = 0;
    interTransferDelay = 32'h03020100;
    for (int i = 0; i < 4; i++) begin
      r = nRise;
      repeat (3) send(2'(i), 1'b0);
      drain;
      check(nRise - r, 1);
    end
    $display("test burst done");
    // keep bit on one select only: held, kept on reuse, released by another or final
    rdyMode = 1;
    for (int i = 0; i < 4; i++) begin
      keepSelectAfterTransfer = 4'h1 << i;
      r = nRise;
      send(2'(i), 1'b0);
      drain;
      check(periphSelectN, 4'(~(4'h1 << i)));
      send(2'(i), 1'b0);
      drain;
      check(nRise - r, 0);
      send(2'(i + 1), 1'b0);
      drain;
      check(nRise - r, 2);
      send(2'(i), 1'b1);
      drain;
      check(periphSelectN, 4'hF);
    end
    $display("test keep done");
    // receiver stalls: launches stop with words queued, then all drain in order
    keepSelectAfterTransfer = 4'hF;
    rdyMode = 2;
    s = 2'($urandom);
    send(s, 1'b0);
    send(s, 1'b0);
    send(s, 1'b1);
    repeat (150) @(negedge core_clk);
    check({txHoldingEmptyFlag, rxValid}, 2'h1);
    rdyMode = 1;
    drain;
    check(periphSelectN, 4'hF);
    $display("test stall done");
    finishTest;
  end
endmodule : spi_chip_select_hold_control_bench
`default_nettype wire
